// file: fss_ctrl.sv
// bus controller end: avalon registers drive write, read and receive byte transfers
module fss_ctrl (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	fss_if.controller bus,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest
);
	import fss_pkg::*;

	logic [1:0] kind;
	logic [6:0] addr;
	logic [7:0] cmd, wdata, rdata, sh;
	logic busy, nack, abort, scl_oe_n, sda_oe_n, sy1, sy2;
	logic [4:0] qc;
	logic [1:0] q;
	logic [2:0] step;
	logic [3:0] bi;

	// slot sequence for each transaction kind
	function automatic fss_slot_t slot_of(input logic [1:0] k, input logic [2:0] s);
		fss_slot_t r;
		r = SL_END;
		if (s == 3'h0) r = SL_START;
		else if (k == KIND_WRITE) r = (s < 3'h4) ? SL_WR : (s == 3'h4) ? SL_STOP : SL_END;
		else if (k == KIND_READ)
			r = (s < 3'h3 || s == 3'h4) ? SL_WR : (s == 3'h3) ? SL_START :
				(s == 3'h5) ? SL_RD : (s == 3'h6) ? SL_STOP : SL_END;
		else r = (s == 3'h1) ? SL_WR : (s == 3'h2) ? SL_RD : (s == 3'h3) ? SL_STOP : SL_END;
		return r;
	endfunction

	wire fss_slot_t slot = abort ? SL_STOP : slot_of(kind, step);
	wire rd_dir = (kind == KIND_RECV && step == 3'h1) || (kind == KIND_READ && step == 3'h4);
	wire [7:0] wbyte = (step == 3'h2) ? cmd : (step == 3'h3) ? wdata : {addr, rd_dir};
	wire tick = busy & (qc == 5'(SCL_QTR - 1));
	wire last_q = tick & (q == 2'h3);
	wire acc = (i_avs_read | i_avs_write) & o_avs_waitrequest;
	wire take_wr = i_avs_write & ~o_avs_waitrequest;
	wire go = take_wr & (i_avs_address == HREG_CTRL) & ~busy;

	// data line input passes two flops
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sy1 <= 1'b1;
			sy2 <= 1'b1;
		end else begin
			sy1 <= bus.sda;
			sy2 <= sy1;
		end
	end

	// avalon slave: one wait cycle, read data loaded with the answer
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0;
		end else begin
			o_avs_waitrequest <= ~acc;
			if (acc && i_avs_read)
				o_avs_readdata <= (i_avs_address == HREG_STAT) ?
					{16'h0, rdata, 6'h00, nack, busy} : 32'h0;
		end
	end

	// bit engine: four quarter phases per bit, clock changes only with data stable
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			kind <= KIND_WRITE;
			addr <= 7'h00;
			cmd <= 8'h00;
			wdata <= 8'h00;
			rdata <= 8'h00;
			sh <= 8'h00;
			busy <= 1'b0;
			nack <= 1'b0;
			abort <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
			qc <= 5'h00;
			q <= 2'h0;
			step <= 3'h0;
			bi <= 4'h0;
		end else if (go) begin
			cmd <= i_avs_writedata[7:0];
			wdata <= i_avs_writedata[15:8];
			addr <= i_avs_writedata[22:16];
			kind <= i_avs_writedata[25:24];
			busy <= 1'b1;
			nack <= 1'b0;
			abort <= 1'b0;
			step <= 3'h0;
			bi <= 4'h0;
			q <= 2'h0;
			qc <= 5'h00;
		end else if (busy) begin
			qc <= tick ? 5'h00 : qc + 5'h01;
			if (tick) begin
				q <= q + 2'h1;
				unique case (slot)
					SL_START: begin
						if (q == 2'h0) sda_oe_n <= 1'b1;
						if (q == 2'h1) scl_oe_n <= 1'b1;
						if (q == 2'h2) sda_oe_n <= 1'b0;
						if (q == 2'h3) scl_oe_n <= 1'b0;
					end
					SL_WR, SL_RD: begin
						if (q == 2'h0) sda_oe_n <= (slot == SL_WR && bi < 4'h8) ? wbyte[3'(4'h7 - bi)]
							: 1'b1; // released for ack or read data; final nack
						if (q == 2'h1) scl_oe_n <= 1'b1;
						if (q == 2'h2 && bi < 4'h8) sh <= {sh[6:0], sy2};
						if (q == 2'h2 && bi == 4'h8 && slot == SL_WR && sy2) begin
							nack <= 1'b1;
							abort <= 1'b1;
						end
						if (q == 2'h2 && bi == 4'h8 && slot == SL_RD) rdata <= sh;
						if (q == 2'h3) scl_oe_n <= 1'b0;
					end
					SL_STOP: begin
						if (q == 2'h3 && bi == 4'h8) scl_oe_n <= 1'b0; // cut ack bit ends low
						if (q == 2'h0) sda_oe_n <= 1'b0;
						if (q == 2'h1) scl_oe_n <= 1'b1;
						if (q == 2'h2) sda_oe_n <= 1'b1;
					end
					SL_END: busy <= 1'b0;
				endcase
			end
			if (last_q) begin
				if ((slot == SL_WR || slot == SL_RD) && bi != 4'h8) bi <= bi + 4'h1;
				else if (abort && bi == 4'h8) bi <= 4'h0; // nacked: a whole stop group follows
				else begin
					bi <= 4'h0;
					step <= (slot == SL_STOP && abort) ? 3'h7 : step + 3'h1;
					if (slot == SL_STOP) abort <= 1'b0;
				end
			end
		end
	end
	assign bus.host_scl_oe_n = scl_oe_n;
	assign bus.host_sda_oe_n = sda_oe_n;
endmodule

// file: fss_if.sv
// two-wire bus joining controller and target, wired-and with pullups
interface fss_if;
	logic host_scl_oe_n;
	logic host_sda_oe_n;
	logic dev_sda_oe_n;
	logic scl;
	logic sda;
	// a low enable pulls the line low, otherwise the pullup wins
	assign scl = host_scl_oe_n;
	assign sda = host_sda_oe_n & dev_sda_oe_n;
	modport target(input scl, input sda, output dev_sda_oe_n);
	modport controller(input scl, input sda, output host_scl_oe_n, output host_sda_oe_n);
endinterface

// file: fss_pkg.sv
// fan speed target: shared constants and types
// Contract
// - only speed-loop tach closes the loop
// - monitor tachs are measured, never regulate
// - override pin: output, input, or force-full
// - alert pin: general open-drain or active-low alert
// - sync pin: general, oscillator out, external clock
// - other pins are open-drain general lines
// - drive tach frequency toward speed reference
// - too fast: increment drive code
// - byte registers reached only over serial bus
// - write byte, read byte, receive byte only
// - receive byte returns last selected register
// - hosts beware pointer changed by others
// - strap low, high, open select addresses
// - ten kilohm pulldown selects 0011 111
// - write byte framing with three acks
// - receive byte framing ends with nack
// - ack is low, nack high, write 0
// - data line open-drain, clock input only
// - pointer resets to zero
// - mode field: full, off, closed, open
package fss_pkg;
	localparam int CLK_HZ = 10_000_000;
	localparam int OSC_HZ = 254_000;
	localparam int OSC_HALF = CLK_HZ / (2 * OSC_HZ);
	localparam int SCL_HZ = 100_000;
	localparam int SCL_QTR = CLK_HZ / (4 * SCL_HZ);
	// target address per strap condition
	localparam logic [1:0] STRAP_LOW = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_OPEN = 2'h2;
	localparam logic [6:0] ADDR_LOW = 7'h48;
	localparam logic [6:0] ADDR_HIGH = 7'h4B;
	localparam logic [6:0] ADDR_OPEN = 7'h1B;
	localparam logic [6:0] ADDR_PD10K = 7'h1F;
	// command bytes
	localparam logic [7:0] CMD_SPEED = 8'h00;
	localparam logic [7:0] CMD_CONFIG = 8'h02;
	localparam logic [7:0] CMD_GPIO_DEF = 8'h04;
	localparam logic [7:0] CMD_DAC = 8'h06;
	localparam logic [7:0] CMD_ALARM_EN = 8'h08;
	localparam logic [7:0] CMD_ALARM = 8'h0A;
	localparam logic [7:0] CMD_SPEED_LOOP_TACH_IN = 8'h0C;
	localparam logic [7:0] CMD_MONITOR_TACH_IN_1 = 8'h0E;
	localparam logic [7:0] CMD_MONITOR_TACH_IN_2 = 8'h10;
	localparam logic [7:0] CMD_MONITOR_TACH_IN_3 = 8'h12;
	localparam logic [7:0] CMD_GPIO_STAT = 8'h14;
	localparam logic [7:0] CMD_COUNT = 8'h16;
	// reset values
	localparam logic [7:0] RST_SPEED = 8'h00;
	localparam logic [7:0] RST_CONFIG = 8'h0A;
	localparam logic [7:0] RST_GPIO_DEF = 8'hFF;
	localparam logic [7:0] RST_DAC = 8'h00;
	localparam logic [7:0] RST_ALARM_EN = 8'h00;
	localparam logic [7:0] RST_COUNT = 8'h02;
	localparam logic [7:0] RST_PTR = 8'h00;
	// field positions
	localparam int CFG_MODE_LSB = 4;
	localparam int DEF_CLK_IN = 2;
	localparam int DEF_ALERT_GEN = 5;
	localparam int DEF_OVR_GEN = 6;
	localparam int DEF_CLK_GEN = 7;
	localparam int ALM_STALL = 0;
	localparam int ALM_SAT = 1;
	localparam int REF_SHIFT = 7;
	localparam logic [7:0] DAC_MAX = 8'hFF;
	localparam logic [7:0] DAC_MIN = 8'h00;
	typedef enum logic [1:0] {
		MODE_FULL = 2'h0, MODE_OFF = 2'h1, MODE_CLOSED = 2'h2, MODE_OPEN = 2'h3
	} fss_mode_t;
	// controller transaction kinds and registers
	localparam logic [1:0] KIND_WRITE = 2'h0;
	localparam logic [1:0] KIND_READ = 2'h1;
	localparam logic [1:0] KIND_RECV = 2'h2;
	localparam logic [3:0] HREG_CTRL = 4'h0;
	localparam logic [3:0] HREG_STAT = 4'h4;
	typedef enum logic [8:0] {
		T_IDLE = 9'h001, T_ADDR = 9'h002, T_ACKA = 9'h004, T_CMD = 9'h008, T_ACKC = 9'h010,
		T_DATA = 9'h020, T_ACKD = 9'h040, T_TX = 9'h080, T_RACK = 9'h100
	} fss_tst_t;
	typedef enum logic [4:0] {
		SL_START = 5'h01, SL_WR = 5'h02, SL_RD = 5'h04, SL_STOP = 5'h08, SL_END = 5'h10
	} fss_slot_t;
endpackage

// file: fss_props.sv
// checker: framing and timing of the target on the two-wire bus
module fss_props (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic host_scl_oe_n,
	input wire logic host_sda_oe_n,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;
	logic scl_q, sda_q, rd, addr_ack;
	logic [3:0] bitn;
	logic [2:0] byten;
	// bus events against the previous sample
	wire start_w = scl & scl_q & sda_q & ~sda;
	wire stop_w = scl & scl_q & ~sda_q & sda;
	wire fall_w = ~scl & scl_q;
	wire rise_w = scl & ~scl_q;
	// bit and byte position since the last start, direction and address ack
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			bitn <= 4'h0;
			byten <= 3'h0;
			rd <= 1'b0;
			addr_ack <= 1'b0;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			if (start_w) begin
				bitn <= 4'hF;
				byten <= 3'h0;
			end else if (fall_w) begin
				bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
				if (bitn == 4'h8)
					byten <= byten + 3'h1;
			end
			if (fall_w && bitn == 4'h7 && byten == 3'h0)
				rd <= sda;
			if (rise_w && bitn == 4'h8 && byten == 3'h0)
				addr_ack <= ~sda;
		end
	end
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);
	addr_quiet_a: assert property (scl && byten == 3'h0 && bitn < 4'h8 |-> dev_sda_oe_n)
		else $error("target drove the address byte");
	host_bytes_a: assert property (scl && byten != 3'h0 && !rd && bitn < 4'h8 |-> dev_sda_oe_n)
		else $error("target drove a host byte");
	nack_free_a: assert property (scl && rd && byten == 3'h1 && bitn == 4'h8 |-> dev_sda_oe_n)
		else $error("target held data in the host nack bit");
	scl_low_change_a: assert property ($changed(dev_sda_oe_n) |-> !scl)
		else $error("target data changed while clock high");
	ack_prompt_a: assert property (fall_w && bitn == 4'h7 && !rd && addr_ack &&
		(byten == 3'h1 || byten == 3'h2) |-> ##[1:6] !dev_sda_oe_n)
		else $error("host byte not acknowledged");
	ack_release_a: assert property (fall_w && bitn == 4'h8 && !(rd && byten == 3'h0)
		|-> ##[1:6] dev_sda_oe_n)
		else $error("ack not released after ninth bit");
	stop_idle_a: assert property (stop_w |=> dev_sda_oe_n [*8])
		else $error("target drove after stop");
	reset_quiet_a: assert property ($rose(i_rstn) |-> dev_sda_oe_n)
		else $error("target drove data out of reset");
	// write byte, host nack of read data, and nacked address seen
	cover property (stop_w && byten == 3'h3 && !rd);
	cover property (fall_w && rd && byten == 3'h1 && bitn == 4'h8);
	cover property (rise_w && bitn == 4'h8 && byten == 3'h0 && sda);
endmodule

// file: fss_target.sv
// fan speed target: serial registers, tach measurement, speed regulator, pins
module fss_target #(
	parameter int P_WIN_TICKS = 254
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	fss_if.target bus,
	input wire logic [1:0] i_addr_strap,
	input wire logic i_speed_loop_tach_in,
	input wire logic i_monitor_tach_in_1,
	input wire logic i_monitor_tach_in_2,
	input wire logic i_monitor_tach_in_3,
	input wire logic i_alert_capable_pin,
	output logic o_alert_capable_pin_oe_n,
	input wire logic i_full_speed_override_pin,
	output logic o_full_speed_override_pin_oe_n,
	input wire logic i_clock_sync_pin,
	output logic o_clock_sync_pin_oe_n,
	input wire logic i_general_pin_3,
	output logic o_general_pin_3_oe_n,
	input wire logic i_general_pin_4,
	output logic o_general_pin_4_oe_n,
	output logic [7:0] o_drive_code
);
	import fss_pkg::*;

	logic [12:0] sy1, sy2, sy3;
	fss_tst_t st;
	logic [7:0] sh, txb, ptr, speed, config_q, gpio_def, alarm_en, alarm, count, dac;
	logic [3:0] bcnt;
	logic rw, sda_oe_n, osc_q;
	logic [4:0] pin_oe_n;
	logic [5:0] osc_cnt;
	logic [17:0] win;
	logic [19:0] pcnt;
	logic [7:0] ecnt [4];
	logic [7:0] tach_cnt [4];

	// every pin passes two flops; the third stage only feeds edge detection
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sy1 <= 13'h1FFF;
			sy2 <= 13'h1FFF;
			sy3 <= 13'h1FFF;
		end else begin
			sy1 <= {i_addr_strap, i_monitor_tach_in_3, i_monitor_tach_in_2, i_monitor_tach_in_1,
				i_speed_loop_tach_in, i_general_pin_4, i_general_pin_3, i_clock_sync_pin,
				i_full_speed_override_pin, i_alert_capable_pin, bus.sda, bus.scl};
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	// bus conditions on the synchronised lines; clock is only ever sampled
	wire scl_rise = sy2[0] & ~sy3[0];
	wire scl_fall = ~sy2[0] & sy3[0];
	wire start_c = sy2[0] & sy3[0] & ~sy2[1] & sy3[1];
	wire stop_c = sy2[0] & sy3[0] & sy2[1] & ~sy3[1];
	wire [1:0] strap = sy2[12:11];
	wire [6:0] my_addr = (strap == STRAP_LOW) ? ADDR_LOW :
		(strap == STRAP_HIGH) ? ADDR_HIGH :
		(strap == STRAP_OPEN) ? ADDR_OPEN : ADDR_PD10K;
	wire byte_done = scl_fall & (bcnt == 4'h8);
	wire wr_en = byte_done & (st == T_DATA);
	wire rd_go = scl_fall & (st == T_ACKA) & rw;
	wire alarm_clr = rd_go & (ptr == CMD_ALARM);
	wire [3:0] tach_rise = sy2[10:7] & ~sy3[10:7];

	// register read selection
	function automatic logic [7:0] rd_sel(input logic [7:0] p);
		case (p)
			CMD_SPEED: rd_sel = speed;
			CMD_CONFIG: rd_sel = config_q;
			CMD_GPIO_DEF: rd_sel = gpio_def;
			CMD_DAC: rd_sel = dac;
			CMD_ALARM_EN: rd_sel = alarm_en;
			CMD_ALARM: rd_sel = alarm;
			CMD_SPEED_LOOP_TACH_IN: rd_sel = tach_cnt[0];
			CMD_MONITOR_TACH_IN_1: rd_sel = tach_cnt[1];
			CMD_MONITOR_TACH_IN_2: rd_sel = tach_cnt[2];
			CMD_MONITOR_TACH_IN_3: rd_sel = tach_cnt[3];
			CMD_GPIO_STAT: rd_sel = {3'h0, sy2[6:2]};
			CMD_COUNT: rd_sel = count;
			default: rd_sel = 8'h00;
		endcase
	endfunction
	wire [7:0] rd_data = rd_sel(ptr);

	// byte framing: shift on clock rise, act on clock fall
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st <= T_IDLE;
			sh <= 8'h00;
			txb <= 8'h00;
			bcnt <= 4'h0;
			rw <= 1'b0;
			ptr <= RST_PTR;
			sda_oe_n <= 1'b1;
		end else if (start_c) begin
			st <= T_ADDR; // repeated start also lands here
			bcnt <= 4'h0;
			sda_oe_n <= 1'b1;
		end else if (stop_c) begin
			st <= T_IDLE;
			sda_oe_n <= 1'b1;
		end else begin
			if (scl_rise) begin
				sh <= {sh[6:0], sy2[1]};
				bcnt <= bcnt + 4'h1;
			end
			if (scl_fall) begin
				unique case (st)
					T_IDLE: ;
					T_ADDR: if (bcnt == 4'h8) begin
						bcnt <= 4'h0;
						if (sh[7:1] == my_addr) begin
							rw <= sh[0];
							st <= T_ACKA;
							sda_oe_n <= 1'b0; // ack holds data low
						end else begin
							st <= T_IDLE;
						end
					end
					T_ACKA: begin
						bcnt <= 4'h0;
						if (rw) begin
							st <= T_TX; // receive byte / read byte data
							sda_oe_n <= rd_data[7];
							txb <= {rd_data[6:0], 1'b0};
						end else begin
							st <= T_CMD;
							sda_oe_n <= 1'b1;
						end
					end
					T_CMD: if (bcnt == 4'h8) begin
						ptr <= sh; // command selects and keeps the register
						bcnt <= 4'h0;
						st <= T_ACKC;
						sda_oe_n <= 1'b0;
					end
					T_ACKC: begin
						bcnt <= 4'h0;
						st <= T_DATA;
						sda_oe_n <= 1'b1;
					end
					T_DATA: if (bcnt == 4'h8) begin
						bcnt <= 4'h0;
						st <= T_ACKD;
						sda_oe_n <= 1'b0;
					end
					T_ACKD: begin
						st <= T_IDLE; // further bytes are not acknowledged
						sda_oe_n <= 1'b1;
					end
					T_TX: if (bcnt == 4'h8) begin
						bcnt <= 4'h0;
						st <= T_RACK;
						sda_oe_n <= 1'b1;
					end else begin
						sda_oe_n <= txb[7]; // open-drain data out
						txb <= {txb[6:0], 1'b0};
					end
					T_RACK: st <= T_IDLE;
				endcase
			end
		end
	end
	assign bus.dev_sda_oe_n = sda_oe_n;

	// software written registers
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			speed <= RST_SPEED;
			config_q <= RST_CONFIG;
			gpio_def <= RST_GPIO_DEF;
			alarm_en <= RST_ALARM_EN;
			count <= RST_COUNT;
		end else if (wr_en) begin
			case (ptr)
				CMD_SPEED: speed <= sh;
				CMD_CONFIG: config_q <= {2'h0, sh[5:0]};
				CMD_GPIO_DEF: gpio_def <= sh;
				CMD_ALARM_EN: alarm_en <= sh;
				CMD_COUNT: count <= sh;
				default: ;
			endcase
		end
	end

	// oscillator: internal divider, or rising edges of the sync pin
	wire clk_fn = ~gpio_def[DEF_CLK_GEN];
	wire ext_clk = clk_fn & gpio_def[DEF_CLK_IN];
	wire int_tick = (osc_cnt == 6'(OSC_HALF - 1)) & ~osc_q;
	wire tick = ext_clk ? (sy2[4] & ~sy3[4]) : int_tick;
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			osc_cnt <= 6'h00;
			osc_q <= 1'b0;
		end else if (osc_cnt == 6'(OSC_HALF - 1)) begin
			osc_cnt <= 6'h00;
			osc_q <= ~osc_q;
		end else begin
			osc_cnt <= osc_cnt + 6'h01;
		end
	end

	// tach edge counts over a window of oscillator ticks, all four inputs
	wire [17:0] win_len = 18'(P_WIN_TICKS) << count[1:0];
	wire win_end = tick & (win >= win_len - 18'h1);
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			win <= 18'h0;
			for (int i = 0; i < 4; i++) begin
				ecnt[i] <= 8'h00;
				tach_cnt[i] <= 8'h00;
			end
		end else begin
			if (tick) win <= win_end ? 18'h0 : win + 18'h1;
			for (int i = 0; i < 4; i++) begin
				if (win_end) begin
					tach_cnt[i] <= ecnt[i]; // monitors only report
					ecnt[i] <= 8'h00;
				end else if (tach_rise[i] && ecnt[i] != 8'hFF) begin
					ecnt[i] <= ecnt[i] + 8'h01;
				end
			end
		end
	end

	// regulator: tach period in scaled ticks against the speed reference
	wire [7:0] kscale = 8'h01 << config_q[2:0];
	wire [19:0] ref_per = 20'({12'h000, speed} + 20'h1) << REF_SHIFT;
	wire too_fast = pcnt < ref_per;
	wire too_slow = pcnt > ref_per;
	wire loop_ev = tach_rise[0];
	fss_mode_t mode;
	assign mode = fss_mode_t'(config_q[CFG_MODE_LSB +: 2]);
	wire ovr_force = ~gpio_def[DEF_OVR_GEN] & gpio_def[1] & ~sy2[3];
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pcnt <= 20'h0;
			dac <= RST_DAC;
		end else begin
			if (loop_ev) pcnt <= 20'h0;
			else if (tick && pcnt < 20'hFFF00) pcnt <= pcnt + 20'(kscale);
			if (ovr_force) dac <= DAC_MIN;
			else unique case (mode)
				MODE_FULL: dac <= DAC_MIN;
				MODE_OFF: dac <= DAC_MAX;
				MODE_CLOSED: if (loop_ev) begin
					if (too_fast && dac != DAC_MAX) dac <= dac + 8'h01;
					else if (too_slow && dac != DAC_MIN) dac <= dac - 8'h01;
				end
				MODE_OPEN: if (wr_en && ptr == CMD_DAC) dac <= sh;
			endcase
		end
	end
	assign o_drive_code = dac;

	// sticky alarms; a new event wins over the read clear
	wire sat_ev = (mode == MODE_CLOSED) & loop_ev &
		((too_fast & dac == DAC_MAX) | (too_slow & dac == DAC_MIN));
	wire stall_ev = win_end & (ecnt[0] == 8'h00);
	wire [7:0] alarm_set = {6'h00, sat_ev, stall_ev};
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) alarm <= 8'h00;
		else alarm <= (alarm & {8{~alarm_clr}}) | alarm_set;
	end

	// pin drivers: a zero level bit pulls a general pin low; pin 0 may carry the alert, pin 2 the oscillator
	wire alert_n = ~|(alarm & alarm_en);
	wire [4:0] next_oe_n = {gpio_def[4:3],
		clk_fn ? (gpio_def[DEF_CLK_IN] | osc_q) : gpio_def[2],
		gpio_def[1],
		gpio_def[DEF_ALERT_GEN] ? gpio_def[0] : alert_n};
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) pin_oe_n <= 5'h1F;
		else pin_oe_n <= next_oe_n;
	end
	assign o_alert_capable_pin_oe_n = pin_oe_n[0];
	assign o_full_speed_override_pin_oe_n = pin_oe_n[1];
	assign o_clock_sync_pin_oe_n = pin_oe_n[2];
	assign o_general_pin_3_oe_n = pin_oe_n[3];
	assign o_general_pin_4_oe_n = pin_oe_n[4];
endmodule

// file: fss_tb.sv
// testbench: controller and target on one bus, driven over avalon
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import fss_pkg::*;
	logic i_clk_sys, i_rstn, av_read, av_write, av_wait, speed_loop_tach_in, mon_run;
	logic [3:0] av_addr;
	logic [31:0] av_wdata, av_rdata;
	logic [1:0] strap;
	logic [2:0] mon;
	logic [4:0] ext_lvl;
	logic [6:0] dev_addr;
	logic [7:0] drive;
	wire [4:0] pin_oe_n;
	wire [4:0] pin = pin_oe_n & ext_lvl;
	int mismatches = 0;
	int n_compared = 0;
	logic [6:0] addr_tab [4] = '{ADDR_LOW, ADDR_HIGH, ADDR_OPEN, ADDR_PD10K};
	logic [7:0] mode_code [4] = '{8'h00, 8'hFF, 8'h00, 8'h5A};
	fss_if bus_if();
	fss_ctrl fss_ctrl_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .bus(bus_if.controller),
		.i_avs_address(av_addr), .i_avs_read(av_read), .i_avs_write(av_write),
		.i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait));
	fss_target #(.P_WIN_TICKS(8)) fss_target_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.bus(bus_if.target), .i_addr_strap(strap), .i_speed_loop_tach_in(speed_loop_tach_in),
		.i_monitor_tach_in_1(mon[0]), .i_monitor_tach_in_2(mon[1]), .i_monitor_tach_in_3(mon[2]),
		.i_alert_capable_pin(pin[0]), .o_alert_capable_pin_oe_n(pin_oe_n[0]),
		.i_full_speed_override_pin(pin[1]), .o_full_speed_override_pin_oe_n(pin_oe_n[1]),
		.i_clock_sync_pin(pin[2]), .o_clock_sync_pin_oe_n(pin_oe_n[2]),
		.i_general_pin_3(pin[3]), .o_general_pin_3_oe_n(pin_oe_n[3]),
		.i_general_pin_4(pin[4]), .o_general_pin_4_oe_n(pin_oe_n[4]), .o_drive_code(drive));
	fss_props fss_props_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.host_scl_oe_n(bus_if.host_scl_oe_n), .host_sda_oe_n(bus_if.host_sda_oe_n),
		.dev_sda_oe_n(bus_if.dev_sda_oe_n), .scl(bus_if.scl), .sda(bus_if.sda));
	// 10 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	// monitor tachs toggle in the background while enabled
	initial begin
		mon = 3'h0;
		forever begin
			repeat (40) @(posedge i_clk_sys);
			if (mon_run)
				mon <= ~mon;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge i_clk_sys);
		av_addr <= a;
		av_wdata <= d;
		av_write <= wr;
		av_read <= ~wr;
		do @(posedge i_clk_sys); while (av_wait !== 1'b0);
		q = av_rdata;
		av_write <= 1'b0;
		av_read <= 1'b0;
	endtask
	// start one serial transfer and poll until it is done
	task automatic op(input logic [1:0] kind, input logic [6:0] a, input logic [7:0] cmd,
		input logic [7:0] d, output logic [7:0] q, output logic nack);
		logic [31:0] s;
		av_xfer(1'b1, HREG_CTRL, {6'h00, kind, 1'b0, a, d, cmd}, s);
		do av_xfer(1'b0, HREG_STAT, 32'h0, s); while (s[0] !== 1'b0);
		q = s[15:8];
		nack = s[1];
	endtask
	task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] d);
		logic [7:0] q;
		logic nk;
		op(KIND_WRITE, dev_addr, cmd, d, q, nk);
		chk(nk, 1'b0);
	endtask
	task automatic rd_reg(input logic [1:0] kind, input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] q;
		logic nk;
		op(kind, dev_addr, cmd, 8'h00, q, nk);
		chk({nk, q}, {1'b0, exp});
	endtask
	// speed-loop tach: low for lo cycles, then a 50 cycle high pulse
	task automatic pulses(input int n, input int lo);
		repeat (n) begin
			repeat (lo) @(posedge i_clk_sys);
			speed_loop_tach_in <= 1'b1;
			repeat (50) @(posedge i_clk_sys);
			speed_loop_tach_in <= 1'b0;
		end
	endtask
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// watchdog: the tests need about 92k cycles
	initial begin
		#9900us;
		mismatches++;
		stop_test();
	end
	initial begin
		logic [31:0] s;
		logic [7:0] q;
		logic nk;
		int tg;
		logic c_prev;
		{i_rstn, av_read, av_write, speed_loop_tach_in, mon_run} = 5'h00;
		av_addr = 4'h0;
		av_wdata = 32'h0;
		strap = STRAP_LOW;
		ext_lvl = 5'h1F;
		dev_addr = ADDR_LOW;
		repeat (5) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		// unmapped address and control readback give zero
		av_xfer(1'b1, 4'h8, 32'hFFFFFFFF, s);
		av_xfer(1'b0, 4'h8, 32'h0, s);
		chk(s, 32'h0);
		av_xfer(1'b0, HREG_CTRL, 32'h0, s);
		chk(s, 32'h0);
		rd_reg(KIND_RECV, 8'h00, RST_SPEED);
		rd_reg(KIND_READ, CMD_CONFIG, RST_CONFIG);
		rd_reg(KIND_READ, CMD_COUNT, RST_COUNT);
		// every strap code answers at its own address only
		for (int i = 0; i < 4; i++) begin
			strap <= 2'(i);
			dev_addr = addr_tab[i];
			repeat (4) @(posedge i_clk_sys);
			rd_reg(KIND_RECV, 8'h00, RST_COUNT);
			op(KIND_RECV, dev_addr ^ 7'h01, 8'h00, 8'h00, q, nk);
			chk(nk, 1'b1);
		end
		wr_reg(CMD_ALARM_EN, 8'h01);
		rd_reg(KIND_RECV, 8'h00, 8'h01);
		// mode field sets the drive code
		for (int m = 0; m < 4; m++) begin
			if (m != 2) begin
				wr_reg(CMD_CONFIG, {2'b11, 2'(m), 4'h0});
				wr_reg(CMD_DAC, 8'h5A);
				chk(drive, mode_code[m]);
			end
		end
		rd_reg(KIND_READ, CMD_DAC, 8'h5A);
		// override input forces full drive
		wr_reg(CMD_GPIO_DEF, 8'hBF);
		ext_lvl <= 5'h1D;
		repeat (8) @(posedge i_clk_sys);
		chk(drive, 8'h00);
		ext_lvl <= 5'h1F;
		wr_reg(CMD_DAC, 8'h5A); // forced code replaced the open-loop one
		chk(drive, 8'h5A);
		// stall alert on pin 0, pins 3 and 4 pulled low by software
		wr_reg(CMD_GPIO_DEF, 8'hC7);
		repeat (8) @(posedge i_clk_sys);
		chk({pin_oe_n[4:3], pin_oe_n[0]}, 3'b000);
		rd_reg(KIND_READ, CMD_GPIO_STAT, 8'h06);
		// oscillator out toggles every 19 cycles
		wr_reg(CMD_GPIO_DEF, 8'h7B);
		tg = 0;
		repeat (380) begin
			c_prev = pin_oe_n[2];
			@(posedge i_clk_sys);
			if (pin_oe_n[2] !== c_prev)
				tg++;
		end
		chk(tg >= 19 && tg <= 21, 1'b1);
		// closed loop, prescaler 4, from code 00: slow saturates, fast raises, monitors ignored
		wr_reg(CMD_CONFIG, 8'h00);
		wr_reg(CMD_CONFIG, 8'h22);
		pulses(2, 1350);
		chk(drive, 8'h00);
		pulses(12, 50);
		chk(drive >= 8'h0A && drive <= 8'h0C, 1'b1);
		mon_run <= 1'b1;
		pulses(3, 1350);
		chk(drive >= 8'h07 && drive <= 8'h09, 1'b1);
		op(KIND_READ, dev_addr, CMD_MONITOR_TACH_IN_1, 8'h00, q, nk);
		chk(q != 8'h00 && nk == 1'b0, 1'b1);
		mon_run <= 1'b0;
		// a larger speed setting makes the same period count as fast
		wr_reg(CMD_SPEED, 8'hFF);
		pulses(2, 1350);
		chk(drive >= 8'h09 && drive <= 8'h0B, 1'b1);
		// external clock function leaves the sync pin released
		wr_reg(CMD_GPIO_DEF, 8'h7F);
		repeat (40) @(posedge i_clk_sys);
		chk(pin_oe_n[2], 1'b1);
		stop_test();
	end
endmodule
